// ### hdl/sir_pkg.sv
// sir_pkg: constants, bus carriers and the state record of the sensor
// interface register bank.
// assumes an axi4-lite master with 32-bit data and a 12-bit byte address.
package sir_pkg;

   // ----------------------------------------------------------------
   // register indices and byte addresses
   // ----------------------------------------------------------------
   localparam logic [11:0] IDX_DEBUG = 12'h1b0;
   localparam logic [11:0] IDX_COUNT = 12'h1b2;
   localparam logic [11:0] IDX_VECTOR = 12'h1b4;
   localparam logic [11:0] IDX_CTL1 = 12'h1b6;
   localparam logic [11:0] IDX_CTL2 = 12'h1b8;
   localparam logic [11:0] IDX_CFG = 12'h200;
   localparam logic [11:0] ADDR_DEBUG = 12'(IDX_DEBUG * 4);
   localparam logic [11:0] ADDR_COUNT = 12'(IDX_COUNT * 4);
   localparam logic [11:0] ADDR_VECTOR = 12'(IDX_VECTOR * 4);
   localparam logic [11:0] ADDR_CTL1 = 12'(IDX_CTL1 * 4);
   localparam logic [11:0] ADDR_CTL2 = 12'(IDX_CTL2 * 4);
   localparam logic [11:0] ADDR_CFG = 12'(IDX_CFG * 4);

   // ----------------------------------------------------------------
   // field positions
   // ----------------------------------------------------------------
   localparam int C1_ENABLE = 0;
   localparam int C1_TEST = 1;
   localparam int C1_FLAG_LO = 2;
   localparam int C1_FLAG_HI = 8;
   localparam int C1_IE_LO = 9;
   localparam int C1_IE_HI = 15;
   localparam int F_CHANNEL = 2;
   localparam int F_STOP = 3;
   localparam int F_START = 4;
   localparam int F_CNT1 = 5;
   localparam int F_CNT2 = 6;
   localparam int F_STATE6 = 7;
   localparam int F_STATE7 = 8;
   localparam int C2_GROUND = 9;
   localparam int C2_ALT3 = 10;
   localparam int C2_COMMON = 11;
   localparam int C2_GROUP = 12;
   localparam int C2_INVERT = 13;
   localparam int C2_COMP_ON = 14;
   localparam int C2_DAC_ON = 15;
   localparam int CF_CLEAR = 0;

   // ----------------------------------------------------------------
   // reset values and bus answers
   // ----------------------------------------------------------------
   localparam logic [15:0] RST_REG16 = 16'h0000;
   localparam logic [7:0] RST_CFG = 8'h00;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   // comparator source seen by the analog side
   typedef enum logic [1:0] {
      SIR_SRC_CHANNEL,
      SIR_SRC_ALT_LOGIC,
      SIR_SRC_ALT_COMMON,
      SIR_SRC_ALT3
   } sir_src_e;

   // ----------------------------------------------------------------
   // bus carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic awvalid;
      logic [11:0] awaddr;
      logic wvalid;
      logic [31:0] wdata;
      logic [3:0] wstrb;
      logic bready;
      logic arvalid;
      logic [11:0] araddr;
      logic rready;
   } sir_axi_req_s;

   typedef struct packed {
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [31:0] rdata;
      logic [1:0] rresp;
   } sir_axi_rsp_s;

   // whole state of the register bank
   typedef struct packed {
      sir_axi_rsp_s bus;
      logic awHeld;
      logic wHeld;
      logic [11:0] awAddr;
      logic [15:0] wData;
      logic [1:0] wStrb;
      logic [1:0] debugSel;
      logic [7:0] cnt1;
      logic [7:0] cnt2;
      logic [15:0] vector;
      logic [15:0] ctl1;
      logic [15:0] ctl2;
      logic [7:0] cfg;
      logic stopPrev;
      logic [3:0] outPrev;
      logic irq;
      logic dacPower;
      logic compPower;
      logic compOut;
      sir_src_e compSource;
      logic sampleGnd;
   } sir_state_s;

endpackage

// ### hdl/sir_regs.sv
// sir_regs: software register bank of the sensor scanning interface.
// assumes the timing and processing machines deliver their views and
// one-cycle event pulses synchronous to clock.
//
// Chosen here: register access over AXI4-Lite and the address map.

// Behaviour
// R1 - writing debug register bits 1-0 chooses which of four views is read
// R2 - view 1 reads zeros in 15-13, tsm pointer 12-8, state bits 7-0
// R3 - view 2 reads the current timing machine output word
// R4 - view 3 reads zero in bit 15 and bits 11-10
// R5 - view 3 bits 14-12 give the index of the active dac register
// R6 - view 3 bits 9-0 give the value of the active dac register
// R7 - upper counter byte clears while disabled, or on read if enabled
// R8 - lower counter byte clears while disabled, or on read if enabled
// R9 - vector register holds the first state address of the state machine
// R10 - control one bits 15-9 enable interrupts of flags 6 to 0
// R11 - flags 6 and 5 set on entering a state with bit 7 or 6
// R12 - flag 4 sets on the chosen second counter condition, sticky
// R13 - flag 3 sets on the chosen first counter condition, sticky
// R14 - flag 2 sets when a timing sequence begins, sticky
// R15 - flag 1 sets on each rising edge of the stop signal, sticky
// R16 - flag 0 sets on the chosen channel output condition, sticky
// R17 - test bit asks for one test cycle and clears when it ends
// R18 - control one bit 0 enables the whole interface
// R19 - control two bit 15 forces the dac on, else timing machine decides
// R20 - control two bit 14 forces the comparator on, else timing decides
// R21 - control two bit 13 inverts the comparator output
// R22 - bits 12, 11, 10 choose channel, common, alt 3 or logic input
// R23 - bit 9 low ties sample ground to its pin, high hands it to timing
// R24 - interrupt request is high while any flag and its enable are set
module sir_regs
   import sir_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // register bus
   input wire sir_axi_req_s axiReq,
   output sir_axi_rsp_s axiRsp,
   // debug views from the state machines
   input wire logic [15:0] psmLastAddr,
   input wire logic [4:0] tsmPointer,
   input wire logic [7:0] psmState,
   input wire logic [15:0] tsmOutput,
   input wire logic [2:0] activeDacIndex,
   input wire logic [9:0] activeDacValue,
   // events
   input wire logic psmStateLoad,
   input wire logic tsmSeqStart,
   input wire logic sequenceStopSignal,
   input wire logic [3:0] channelOutputs,
   input wire logic cnt1Up,
   input wire logic cnt1Down,
   input wire logic cnt2Down,
   input wire logic testCycleDone,
   // analog requests from the timing machine, raw comparator output
   input wire logic tsmDacOn,
   input wire logic tsmCompOn,
   input wire logic tsmSampleGnd,
   input wire logic compRaw,
   // controls out
   output logic interfaceEnable,
   output logic testCycleRequest,
   output logic [15:0] psmVector,
   output logic dacPower,
   output logic compPower,
   output logic compOut,
   output sir_src_e compSource,
   output logic sampleGndByTsm,
   output logic irq
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   sir_state_s s;
   sir_state_s next_s;

   // byte lane merge of a 16-bit register
   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [15:0] data,
                                           input logic [1:0] strb);
      logic [15:0] r;
      r = old;
      if (strb[0]) begin
         r[7:0] = data[7:0];
      end
      if (strb[1]) begin
         r[15:8] = data[15:8];
      end
      return r;
   endfunction

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   logic writeGo;
   logic readGo;
   logic [11:0] rdAddr;
   logic [11:0] wrAddr;
   logic cntClear;
   logic c1Ev;
   logic c2Ev;
   logic [7:0] c1Base;
   logic [7:0] c2Base;
   logic [7:0] c1New;
   logic [7:0] c2New;
   logic [6:0] flagSet;
   logic [3:0] outRise;
   logic [3:0] outFall;
   logic testWrite;
   logic [15:0] dbgView;

   // bus handshake, register updates and event capture
   always_comb begin
      next_s = s;
      rdAddr = {axiReq.araddr[11:2], 2'h0};
      wrAddr = {s.awAddr[11:2], 2'h0};
      readGo = s.bus.arready && axiReq.arvalid;
      writeGo = s.awHeld && s.wHeld;
      cntClear = 1'b0;
      testWrite = 1'b0;
      flagSet = 7'h00;
      outRise = channelOutputs & ~s.outPrev;
      outFall = ~channelOutputs & s.outPrev;

      // R1 debug view mux
      case (s.debugSel)
         2'h0: dbgView = psmLastAddr;
         // R2 pointer and state bits
         2'h1: dbgView = {3'h0, tsmPointer, psmState};
         // R3 timing output word
         2'h2: dbgView = tsmOutput;
         // R4 R5 R6 active dac view
         default: dbgView = {1'b0, activeDacIndex, 2'h0, activeDacValue};
      endcase

      // write address and data, taken in either order
      if (s.bus.awready && axiReq.awvalid) begin
         next_s.awAddr = axiReq.awaddr;
         next_s.awHeld = 1'b1;
         next_s.bus.awready = 1'b0;
      end
      if (s.bus.wready && axiReq.wvalid) begin
         next_s.wData = axiReq.wdata[15:0];
         next_s.wStrb = axiReq.wstrb[1:0];
         next_s.wHeld = 1'b1;
         next_s.bus.wready = 1'b0;
      end
      if (s.bus.bvalid && axiReq.bready) begin
         next_s.bus.bvalid = 1'b0;
         next_s.bus.awready = 1'b1;
         next_s.bus.wready = 1'b1;
      end

      // register writes
      if (writeGo) begin
         next_s.awHeld = 1'b0;
         next_s.wHeld = 1'b0;
         next_s.bus.bvalid = 1'b1;
         next_s.bus.bresp = RESP_OKAY;
         if (wrAddr == ADDR_DEBUG) begin
            // R1 view select
            if (s.wStrb[0]) begin
               next_s.debugSel = s.wData[1:0];
            end
         end else if (wrAddr == ADDR_COUNT) begin
            {next_s.cnt2, next_s.cnt1} = merge16({s.cnt2, s.cnt1},
                                                  s.wData, s.wStrb);
         end else if (wrAddr == ADDR_VECTOR) begin
            // R9 start vector
            next_s.vector = merge16(s.vector, s.wData, s.wStrb);
         end else if (wrAddr == ADDR_CTL1) begin
            next_s.ctl1 = merge16(s.ctl1, s.wData, s.wStrb);
            testWrite = s.wStrb[0] && s.wData[C1_TEST];
         end else if (wrAddr == ADDR_CTL2) begin
            next_s.ctl2 = merge16(s.ctl2, s.wData, s.wStrb);
         end else if (wrAddr == ADDR_CFG) begin
            if (s.wStrb[0]) begin
               next_s.cfg = s.wData[7:0];
            end
         end else begin
            next_s.bus.bresp = RESP_SLVERR;
         end
      end

      // register reads, answered on the same edge that takes the address
      if (s.bus.rvalid && axiReq.rready) begin
         next_s.bus.rvalid = 1'b0;
         next_s.bus.arready = 1'b1;
      end
      if (readGo) begin
         next_s.bus.arready = 1'b0;
         next_s.bus.rvalid = 1'b1;
         next_s.bus.rresp = RESP_OKAY;
         next_s.bus.rdata = 32'h0000_0000;
         if (rdAddr == ADDR_DEBUG) begin
            next_s.bus.rdata[15:0] = dbgView;
         end else if (rdAddr == ADDR_COUNT) begin
            next_s.bus.rdata[15:0] = {s.cnt2, s.cnt1};
            cntClear = s.cfg[CF_CLEAR];
         end else if (rdAddr == ADDR_VECTOR) begin
            next_s.bus.rdata[15:0] = s.vector;
         end else if (rdAddr == ADDR_CTL1) begin
            next_s.bus.rdata[15:0] = s.ctl1;
         end else if (rdAddr == ADDR_CTL2) begin
            next_s.bus.rdata[15:0] = s.ctl2;
         end else if (rdAddr == ADDR_CFG) begin
            next_s.bus.rdata[7:0] = s.cfg;
         end else begin
            next_s.bus.rresp = RESP_SLVERR;
         end
      end

      // R7 R8 clear on read, then a same-cycle count still lands
      c1Base = cntClear ? 8'h00 : next_s.cnt1;
      c2Base = cntClear ? 8'h00 : next_s.cnt2;
      c1Ev = s.ctl1[C1_ENABLE] && (cnt1Up != cnt1Down);
      c2Ev = s.ctl1[C1_ENABLE] && cnt2Down;
      c1New = cnt1Up ? 8'(c1Base + 8'h01) : 8'(c1Base - 8'h01);
      c2New = 8'(c2Base - 8'h01);
      next_s.cnt1 = c1Ev ? c1New : c1Base;
      next_s.cnt2 = c2Ev ? c2New : c2Base;

      // R13 first counter condition
      case (s.cfg[2:1])
         2'h0: flagSet[F_CNT1 - 2] = c1Ev;
         2'h1: flagSet[F_CNT1 - 2] = c1Ev && (c1New[1:0] == 2'h0);
         2'h2: flagSet[F_CNT1 - 2] = c1Ev && (c1New[5:0] == 6'h00);
         default: flagSet[F_CNT1 - 2] = c1Ev && cnt1Up && (c1Base == 8'hff);
      endcase
      // R12 second counter condition
      case (s.cfg[4:3])
         2'h0: flagSet[F_CNT2 - 2] = c2Ev;
         2'h1: flagSet[F_CNT2 - 2] = c2Ev && (c2New[1:0] == 2'h0);
         2'h2: flagSet[F_CNT2 - 2] = c2Ev && (c2New[5:0] == 6'h00);
         default: flagSet[F_CNT2 - 2] = c2Ev && (c2Base == 8'h01);
      endcase
      // R16 channel output condition, edge chosen by the low bit
      flagSet[F_CHANNEL - 2] = s.cfg[5] ? outFall[s.cfg[7:6]] :
                                          outRise[s.cfg[7:6]];
      // R15 stop signal rising edge
      flagSet[F_STOP - 2] = sequenceStopSignal && !s.stopPrev;
      // R14 sequence start
      flagSet[F_START - 2] = tsmSeqStart;
      // R11 state bits 6 and 7
      flagSet[F_STATE6 - 2] = psmStateLoad && psmState[6];
      flagSet[F_STATE7 - 2] = psmStateLoad && psmState[7];
      next_s.stopPrev = sequenceStopSignal;
      next_s.outPrev = channelOutputs;

      // hardware set wins over a software clear
      next_s.ctl1[C1_FLAG_HI:C1_FLAG_LO] =
         next_s.ctl1[C1_FLAG_HI:C1_FLAG_LO] | flagSet;

      // R17 self clear at end of test cycle unless rewritten now
      if (testCycleDone && !testWrite) begin
         next_s.ctl1[C1_TEST] = 1'b0;
      end

      // R18 R7 R8 counters held clear while disabled
      if (!s.ctl1[C1_ENABLE]) begin
         next_s.cnt1 = 8'h00;
         next_s.cnt2 = 8'h00;
      end

      // R10 R24 masked request
      next_s.irq = |(next_s.ctl1[C1_FLAG_HI:C1_FLAG_LO] &
                     next_s.ctl1[C1_IE_HI:C1_IE_LO]);

      // R19 dac power
      next_s.dacPower = s.ctl2[C2_DAC_ON] || tsmDacOn;
      // R20 comparator power
      next_s.compPower = s.ctl2[C2_COMP_ON] || tsmCompOn;
      // R21 output polarity
      next_s.compOut = compRaw ^ s.ctl2[C2_INVERT];
      // R22 input group choice
      if (!s.ctl2[C2_GROUP]) begin
         next_s.compSource = SIR_SRC_CHANNEL;
      end else if (s.ctl2[C2_COMMON]) begin
         next_s.compSource = SIR_SRC_ALT_COMMON;
      end else if (s.ctl2[C2_ALT3]) begin
         next_s.compSource = SIR_SRC_ALT3;
      end else begin
         next_s.compSource = SIR_SRC_ALT_LOGIC;
      end
      // R23 sample ground hand-over
      next_s.sampleGnd = s.ctl2[C2_GROUND] && tsmSampleGnd;
   end

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   // synchronous reset to a quiet, ready bus
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         next_s_reset: begin
            s <= '0;
            s.bus.awready <= 1'b1;
            s.bus.wready <= 1'b1;
            s.bus.arready <= 1'b1;
            s.ctl1 <= RST_REG16;
            s.ctl2 <= RST_REG16;
            s.vector <= RST_REG16;
            s.cfg <= RST_CFG;
         end
      end else begin
         s <= next_s;
      end
   end

   // outputs straight from the state record
   assign axiRsp = s.bus;
   assign interfaceEnable = s.ctl1[C1_ENABLE];
   assign testCycleRequest = s.ctl1[C1_TEST];
   assign psmVector = s.vector;
   assign dacPower = s.dacPower;
   assign compPower = s.compPower;
   assign compOut = s.compOut;
   assign compSource = s.compSource;
   assign sampleGndByTsm = s.sampleGnd;
   assign irq = s.irq;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);

   sequence s_dbg_read(logic [1:0] v);
      readGo && (rdAddr == ADDR_DEBUG) && (s.debugSel == v);
   endsequence

   sequence s_stop_rise;
      !sequenceStopSignal ##1 sequenceStopSignal;
   endsequence

   property p_view1;
      s_dbg_read(2'h1) |=> s.bus.rvalid && (s.bus.rdata[15:13] == 3'h0)
         && (s.bus.rdata[12:8] == $past(tsmPointer))
         && (s.bus.rdata[7:0] == $past(psmState));
   endproperty
   a_view1: assert property (p_view1) else $error("view 1 wrong"); // R2

   property p_view2;
      s_dbg_read(2'h2) |=> s.bus.rdata[15:0] == $past(tsmOutput);
   endproperty
   a_view2: assert property (p_view2) else $error("view 2 wrong"); // R3

   property p_view3_zero;
      s_dbg_read(2'h3) |=> !s.bus.rdata[15] && (s.bus.rdata[11:10] == 2'h0);
   endproperty
   a_view3_zero: assert property (p_view3_zero) else $error("v3 zeros"); // R4

   property p_view3_index;
      s_dbg_read(2'h3) |=> s.bus.rdata[14:12] == $past(activeDacIndex);
   endproperty
   a_view3_index: assert property (p_view3_index) else $error("v3 idx"); // R5

   property p_view3_data;
      s_dbg_read(2'h3) |=> s.bus.rdata[9:0] == $past(activeDacValue);
   endproperty
   a_view3_data: assert property (p_view3_data) else $error("v3 dat"); // R6

   property p_cnt2_off;
      !s.ctl1[C1_ENABLE] |=> s.cnt2 == 8'h00;
   endproperty
   a_cnt2_off: assert property (p_cnt2_off) else $error("cnt2 held"); // R7

   property p_cnt1_off;
      !s.ctl1[C1_ENABLE] |=> s.cnt1 == 8'h00;
   endproperty
   a_cnt1_off: assert property (p_cnt1_off) else $error("cnt1 held"); // R8

   property p_irq;
      (|(s.ctl1[C1_FLAG_HI:C1_FLAG_LO] & s.ctl1[C1_IE_HI:C1_IE_LO]))
         == s.irq;
   endproperty
   a_irq: assert property (p_irq) else $error("irq mismatch"); // R24

   // flag set at once, then kept unless software wrote in between
   property p_state7;
      psmStateLoad && psmState[7] |=> s.ctl1[F_STATE7]
         ##1 (s.ctl1[F_STATE7] || $past(writeGo));
   endproperty
   a_state7: assert property (p_state7) else $error("flag 6 lost"); // R11

   property p_start;
      tsmSeqStart |=> s.ctl1[F_START];
   endproperty
   a_start: assert property (p_start) else $error("flag 2 lost"); // R14

   property p_stop;
      s_stop_rise |=> s.ctl1[F_STOP];
   endproperty
   a_stop: assert property (p_stop) else $error("flag 1 lost"); // R15

   property p_test;
      testCycleDone && !writeGo |=> !s.ctl1[C1_TEST];
   endproperty
   a_test: assert property (p_test) else $error("test bit kept"); // R17

   property p_dac;
      s.ctl2[C2_DAC_ON] |=> s.dacPower;
   endproperty
   a_dac: assert property (p_dac) else $error("dac not forced"); // R19

   property p_invert;
      ##1 s.compOut == ($past(compRaw) ^ $past(s.ctl2[C2_INVERT]));
   endproperty
   a_invert: assert property (p_invert) else $error("polarity"); // R21

endmodule

// ### verification/sir_regs_tb.sv
// sir_regs_tb: self-checking bench of the sensor interface register bank.
// assumes sir_pkg and sir_regs compiled first; bench acts as axi master.
module sir_regs_tb
   import sir_pkg::*;
;
   timeunit 1ns;
   timeprecision 100ps;

   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   logic clock = 1'b0;
   logic sys_rst = 1'b1;
   sir_axi_req_s axiReq = '0;
   sir_axi_rsp_s axiRsp;
   logic [15:0] psmLastAddr = 16'hbeef;
   logic [4:0] tsmPointer = 5'h15;
   logic [7:0] psmState = 8'h3c;
   logic [15:0] tsmOutput = 16'ha5c3;
   logic [2:0] activeDacIndex = 3'h5;
   logic [9:0] activeDacValue = 10'h2a7;
   logic psmStateLoad = 1'b0, tsmSeqStart = 1'b0, stopSig = 1'b0;
   logic [3:0] channelOutputs = 4'h0;
   logic cnt1Up = 1'b0, cnt2Down = 1'b0, testCycleDone = 1'b0;
   logic cnt1Down = 1'b0;
   logic [3:0] tsmIn = 4'h0;
   logic interfaceEnable, testCycleRequest, dacPower, compPower, compOut;
   logic sampleGndByTsm, irq;
   logic [15:0] psmVector;
   sir_src_e compSource;
   int errors = 0;
   int comparisons = 0;
   logic [31:0] rdVal;
   logic [1:0] resp;

   always #2.5 clock = ~clock;

   sir_regs dut (.clock(clock), .sys_rst(sys_rst), .axiReq(axiReq),
      .axiRsp(axiRsp), .psmLastAddr(psmLastAddr), .tsmPointer(tsmPointer),
      .psmState(psmState), .tsmOutput(tsmOutput),
      .activeDacIndex(activeDacIndex), .activeDacValue(activeDacValue),
      .psmStateLoad(psmStateLoad), .tsmSeqStart(tsmSeqStart),
      .sequenceStopSignal(stopSig), .channelOutputs(channelOutputs),
      .cnt1Up(cnt1Up), .cnt1Down(cnt1Down), .cnt2Down(cnt2Down),
      .testCycleDone(testCycleDone), .tsmDacOn(tsmIn[3]),
      .tsmCompOn(tsmIn[2]), .tsmSampleGnd(tsmIn[1]), .compRaw(tsmIn[0]),
      .interfaceEnable(interfaceEnable), .testCycleRequest(testCycleRequest),
      .psmVector(psmVector), .dacPower(dacPower), .compPower(compPower),
      .compOut(compOut), .compSource(compSource),
      .sampleGndByTsm(sampleGndByTsm), .irq(irq));

   // ----------------------------------------------------------------
   // checking and closing
   // ----------------------------------------------------------------
   task automatic give_verdict();
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   // ----------------------------------------------------------------
   // axi4-lite master tasks, ready sampled at the settled half cycle
   // ----------------------------------------------------------------
   task automatic axi_write(input logic [11:0] a, input logic [15:0] d);
      int n;
      logic awT, wT, bT;
      bT = 1'b0;
      @(posedge clock);
      axiReq.awvalid <= 1'b1;
      axiReq.awaddr <= a;
      axiReq.wvalid <= 1'b1;
      axiReq.wdata <= {16'h0000, d};
      axiReq.wstrb <= 4'hf;
      axiReq.bready <= 1'b1;
      for (n = 0; n < 64 && !bT; n++) begin
         @(negedge clock);
         awT = axiReq.awvalid & axiRsp.awready;
         wT = axiReq.wvalid & axiRsp.wready;
         bT = axiRsp.bvalid;
         resp = axiRsp.bresp;
         @(posedge clock);
         if (awT) axiReq.awvalid <= 1'b0;
         if (wT) axiReq.wvalid <= 1'b0;
         if (bT) axiReq.bready <= 1'b0;
      end
      // let the outputs settle before the caller looks at them
      @(negedge clock);
      if (!bT) begin
         check(32'h0, 32'h1);
         give_verdict();
      end
   endtask

   task automatic axi_read(input logic [11:0] a);
      int n;
      logic arT, rT;
      rT = 1'b0;
      @(posedge clock);
      axiReq.arvalid <= 1'b1;
      axiReq.araddr <= a;
      axiReq.rready <= 1'b1;
      for (n = 0; n < 64 && !rT; n++) begin
         @(negedge clock);
         arT = axiReq.arvalid & axiRsp.arready;
         rT = axiRsp.rvalid;
         rdVal = axiRsp.rdata;
         resp = axiRsp.rresp;
         @(posedge clock);
         if (arT) axiReq.arvalid <= 1'b0;
         if (rT) axiReq.rready <= 1'b0;
      end
      if (!rT) begin
         check(32'h0, 32'h1);
         give_verdict();
      end
   endtask

   task automatic rd_check(input logic [11:0] a, input logic [15:0] exp);
      axi_read(a);
      check(rdVal, {16'h0000, exp});
   endtask

   // one event of kind k, flag bit 2+k; kind 7 counts the first one down
   task automatic fire(input int k);
      @(posedge clock);
      case (k)
         0: channelOutputs <= 4'h1;
         1: stopSig <= 1'b1;
         2: tsmSeqStart <= 1'b1;
         3: cnt1Up <= 1'b1;
         4: cnt2Down <= 1'b1;
         5: psmState <= 8'h40;
         7: cnt1Down <= 1'b1;
         default: psmState <= 8'h80;
      endcase
      if (k == 5 || k == 6) psmStateLoad <= 1'b1;
      @(posedge clock);
      {channelOutputs, stopSig, tsmSeqStart} <= '0;
      {cnt1Up, cnt1Down, cnt2Down, psmStateLoad} <= '0;
      @(negedge clock);
   endtask

   // ctl2 setting against timing requests, outputs one edge later
   task automatic ctl2_case(input logic [15:0] v, input logic [3:0] t,
                            input logic [3:0] exp, input sir_src_e src);
      axi_write(ADDR_CTL2, v);
      @(posedge clock);
      tsmIn <= t;
      repeat (2) @(negedge clock);
      check({dacPower, compPower, compOut, sampleGndByTsm}, exp);
      check(32'(compSource), 32'(src));
      rd_check(ADDR_CTL2, v);
   endtask

   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (5) @(posedge clock);
      sys_rst <= 1'b0;
      rd_check(ADDR_CTL1, 16'h0000);
      rd_check(ADDR_CTL2, 16'h0000);
      rd_check(ADDR_COUNT, 16'h0000);
      axi_read(12'h004);
      check(rdVal, 32'h0);
      check(resp, RESP_SLVERR);
      axi_write(12'h004, 16'hffff);
      check(resp, RESP_SLVERR);
      // debug views in turn
      for (int k = 0; k < 4; k++) begin
         axi_write(ADDR_DEBUG, 16'(k));
         axi_read(ADDR_DEBUG);
         case (k)
            0: check(rdVal, 32'h0000beef);
            1: check(rdVal, 32'h0000153c);
            2: check(rdVal, 32'h0000a5c3);
            default: check(rdVal, 32'h000052a7);
         endcase
      end
      axi_write(ADDR_VECTOR, 16'h1234);
      check(psmVector, 16'h1234);
      rd_check(ADDR_VECTOR, 16'h1234);
      // each flag with and without its enable
      for (int k = 0; k < 7; k++) begin
         axi_write(ADDR_CTL1, 16'h0001 | (16'h0200 << k));
         check(irq, 1'b0);
         fire(k);
         check(irq, 1'b1);
         rd_check(ADDR_CTL1, 16'h0001 | (16'h0204 << k));
         axi_write(ADDR_CTL1, 16'h0001 | (16'h0004 << k));
         @(negedge clock);
         check(irq, 1'b0);
         rd_check(ADDR_CTL1, 16'h0001 | (16'h0004 << k));
      end
      // counters: clear while disabled, count, clear on read
      axi_write(ADDR_CTL1, 16'h0000);
      check(interfaceEnable, 1'b0);
      rd_check(ADDR_COUNT, 16'h0000);
      axi_write(ADDR_CTL1, 16'h0001);
      check(interfaceEnable, 1'b1);
      axi_write(ADDR_COUNT, 16'h0500);
      fire(3);
      fire(3);
      fire(4);
      fire(7);
      fire(3);
      rd_check(ADDR_COUNT, 16'h0402);
      axi_write(ADDR_CFG, 16'h0001);
      rd_check(ADDR_COUNT, 16'h0402);
      rd_check(ADDR_COUNT, 16'h0000);
      axi_write(ADDR_CFG, 16'h0000);
      // test cycle bit clears itself when the cycle ends
      axi_write(ADDR_CTL1, 16'h0003);
      check(testCycleRequest, 1'b1);
      @(posedge clock);
      testCycleDone <= 1'b1;
      @(posedge clock);
      testCycleDone <= 1'b0;
      @(negedge clock);
      check(testCycleRequest, 1'b0);
      rd_check(ADDR_CTL1, 16'h0001);
      // counter flag sources: modulo 4, and the step from 01h to 00h
      axi_write(ADDR_COUNT, 16'h0203);
      axi_write(ADDR_CFG, 16'h001a);
      fire(4);
      fire(3);
      rd_check(ADDR_CTL1, 16'h0021);
      fire(4);
      rd_check(ADDR_CTL1, 16'h0061);
      axi_write(ADDR_CFG, 16'h0000);
      // dac, comparator, input group and sample ground
      ctl2_case(16'h8000, 4'h3, 4'ha, SIR_SRC_CHANNEL);
      ctl2_case(16'h7200, 4'h3, 4'h5, SIR_SRC_ALT_LOGIC);
      ctl2_case(16'h1800, 4'hc, 4'hc, SIR_SRC_ALT_COMMON);
      ctl2_case(16'h1400, 4'h1, 4'h2, SIR_SRC_ALT3);
      ctl2_case(16'h2c00, 4'h0, 4'h2, SIR_SRC_CHANNEL);
      give_verdict();
   end
endmodule
